/* File: src/mpwt_pkg.sv */
// package: offsets, field positions, reset values, modes and carriers
// assumes: a 32-bit AXI4-Lite master with byte addresses in the low 8 bits
package mpwt_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PSC  = 8'h04;
	localparam logic [7:0] OFF_ARR  = 8'h08;
	localparam logic [7:0] OFF_CNT  = 8'h0c;
	localparam logic [7:0] OFF_STAT = 8'h10;
	localparam logic [7:0] OFF_CLR  = 8'h14;
	localparam logic [7:0] OFF_IE   = 8'h18;
	localparam logic [7:0] OFF_DMAE = 8'h1c;
	localparam logic [7:0] OFF_DT   = 8'h20;
	localparam logic [7:0] OFF_MODE = 8'h24;
	localparam logic [7:0] OFF_CCR0 = 8'h30;

	// control register fields
	localparam int CTRL_EN     = 0;
	localparam int CTRL_DOWN   = 1;
	localparam int CTRL_CENTER = 2;
	localparam int CTRL_OPM    = 3;
	localparam int CTRL_FRZ    = 4;
	localparam int CTRL_SMS    = 5;
	localparam int CTRL_OE     = 7;

	// status, clear, enable and dma-enable bit positions
	localparam int ST_UPD  = 0;
	localparam int ST_CC0  = 1;
	localparam int ST_TRG  = 5;
	localparam int ST_HALL = 6;
	localparam int ST_W    = 7;

	// reset values and bus responses
	localparam logic [31:0] ARR_RST = 32'hffff_ffff;
	localparam logic [1:0]  RESP_OK  = 2'b00;
	localparam logic [1:0]  RESP_ERR = 2'b10;

	typedef enum logic [2:0] {
		CC_OFF, CC_CAP_RISE, CC_CAP_FALL, CC_TOGGLE, CC_PWM
	} mpwt_cc_mode_t;

	typedef enum logic [1:0] {SM_FREE, SM_ENC, SM_TRIG, SM_HALL} mpwt_slave_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} mpwt_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} mpwt_axi_rsp_t;

	typedef struct packed {
		mpwt_axi_rsp_t    rsp;
		logic             aw_held;
		logic [7:0]       awaddr;
		logic             w_held;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic [7:0]       ctrl;
		logic [15:0]      psc;
		logic [15:0]      pcnt;
		logic [31:0]      arr;
		logic [31:0]      cnt;
		logic             cdown;
		logic [ST_W-1:0]  status;
		logic [ST_W-1:0]  ie;
		logic [ST_W-1:0]  dmae;
		logic [7:0]       dt;
		logic [11:0]      mode;
		logic [3:0][31:0] ccr;
		logic [3:0]       ch_out;
		logic [3:0]       ch_oe;
		logic [3:0]       in_q;
		logic             trig_q;
		logic             trig_out;
		logic             irq;
		logic [ST_W-1:0]  dma_req;
	} mpwt_state_t;

	typedef struct packed {
		logic       ref_q;
		logic [7:0] cnt;
		logic       p;
		logic       n;
	} mpwt_dt_state_t;

endpackage

/* File: src/mpwt_deadtime.sv */
// one complementary output pair with dead-time insertion
// assumes: ref is a registered level of the same clock
`timescale 1ns/1ps
module mpwt_deadtime (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// control
	input  wire logic       ref_lvl,
	input  wire logic       en,
	input  wire logic [7:0] dt,
	// pair
	output logic            out_p,
	output logic            out_n
);
	import mpwt_pkg::*;

	mpwt_dt_state_t s;
	mpwt_dt_state_t next_s;

	always_comb begin
		next_s = s;
		if (!en) begin
			next_s.ref_q = ref_lvl;
			next_s.cnt   = 8'h00;
			next_s.p     = 1'b0;
			next_s.n     = 1'b0;
		end else if (ref_lvl != s.ref_q) begin
			// both inactive while the gap runs
			next_s.ref_q = ref_lvl;
			next_s.cnt   = dt;
			next_s.p     = 1'b0;
			next_s.n     = 1'b0;
		end else if (s.cnt != 8'h00) begin
			next_s.cnt = s.cnt - 8'h01;
		end else begin
			next_s.p = ref_lvl;
			next_s.n = !ref_lvl;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign out_p = s.p;
	assign out_n = s.n;

	////////////////////////////////////////////////////////////////////////////
	a_pair_no_overlap: assert property (@(posedge aclk) disable iff (!aresetn)
		!(out_p && out_n))
		else $error("both outputs of the pair active");

	a_pair_gap_rise: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(out_p) |-> $past(!out_n) && $past(s.cnt) == 8'h00)
		else $error("output rose without a completed dead time");

endmodule

/* File: src/mpwt_timer.sv */
// configurable pwm timer: counter, prescaler, channels, dead time, axi4-lite
// assumes: pins synchronous to aclk, one axi write and one read at a time
`timescale 1ns/1ps
module mpwt_timer #(
	parameter int CNT_W     = 16,
	parameter int NUM_CH    = 4,
	parameter int NUM_COMPL = 3,
	parameter bit UP_ONLY   = 1'b0,
	parameter bit HAS_DMA   = 1'b1
) (
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// register bus
	input  wire mpwt_pkg::mpwt_axi_req_t axi_req,
	output mpwt_pkg::mpwt_axi_rsp_t    axi_rsp,
	// channel pins
	input  wire logic [3:0]            ch_in,
	output logic [3:0]                 ch_out,
	output logic [3:0]                 ch_oe,
	output logic [2:0]                 ch_out_n,
	// system
	input  wire logic                  dbg_halt,
	input  wire logic                  trig_in,
	output logic                       trig_out,
	output logic                       irq,
	output logic [mpwt_pkg::ST_W-1:0]  dma_req
);
	import mpwt_pkg::*;

	localparam logic [32:0] CM33  = (33'h1 << CNT_W) - 33'h1;
	localparam logic [31:0] CMASK = CM33[31:0];

	if (!(CNT_W == 16 || CNT_W == 32) || NUM_CH < 1 || NUM_CH > 4 ||
	    NUM_COMPL < 0 || NUM_COMPL > 3 || NUM_COMPL > NUM_CH) begin : g_bad
		$error("mpwt_timer: unsupported parameter set");
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
	                                      input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	// {wrapped, new count} for one step
	function automatic logic [32:0] step(input logic [31:0] c, input logic [31:0] a,
	                                     input logic dn);
		logic [32:0] r;
		if (dn) begin
			r = (c == 32'h0) ? {1'b1, a} : {1'b0, c - 32'h1};
		end else begin
			r = (c >= a) ? {1'b1, 32'h0} : {1'b0, c + 32'h1};
		end
		return r;
	endfunction

	mpwt_state_t     s;
	mpwt_state_t     next_s;
	logic            run;
	logic            tick;
	logic            upd;
	logic            wr_fire;
	logic            wr_cnt;
	logic            hit;
	logic [31:0]     wv;
	logic [32:0]     st;
	logic [ST_W-1:0] set;
	logic [ST_W-1:0] clr;
	mpwt_slave_t     sms;
	mpwt_cc_mode_t   m;

	always_comb begin
		next_s  = s;
		tick    = 1'b0;
		upd     = 1'b0;
		set     = '0;
		clr     = '0;
		hit     = 1'b1;
		wr_cnt  = 1'b0;
		st      = '0;
		m       = CC_OFF;
		sms     = mpwt_slave_t'(s.ctrl[CTRL_SMS +: 2]);
		run     = s.ctrl[CTRL_EN] && !(dbg_halt && s.ctrl[CTRL_FRZ]);
		wr_fire = s.aw_held && s.w_held && !s.rsp.bvalid;
		wv      = '0;

		////////////////////////////////////////////////////////////////////////
		// bus write path
		if (axi_req.awvalid && s.rsp.awready) begin
			next_s.aw_held = 1'b1;
			next_s.awaddr  = axi_req.awaddr;
		end
		if (axi_req.wvalid && s.rsp.wready) begin
			next_s.w_held = 1'b1;
			next_s.wdata  = axi_req.wdata;
			next_s.wstrb  = axi_req.wstrb;
		end
		if (s.rsp.bvalid && axi_req.bready) begin
			next_s.rsp.bvalid = 1'b0;
		end
		if (wr_fire) begin
			next_s.aw_held = 1'b0;
			next_s.w_held  = 1'b0;
			case (s.awaddr)
				OFF_CTRL: begin
					wv = merge({24'h0, s.ctrl}, s.wdata, s.wstrb);
					next_s.ctrl = wv[7:0];
					if (UP_ONLY) begin
						next_s.ctrl[CTRL_DOWN]   = 1'b0;
						next_s.ctrl[CTRL_CENTER] = 1'b0;
					end
				end
				OFF_PSC: begin
					wv = merge({16'h0, s.psc}, s.wdata, s.wstrb);
					next_s.psc = wv[15:0];
				end
				OFF_ARR:  next_s.arr = merge(s.arr, s.wdata, s.wstrb) & CMASK;
				OFF_CNT: begin
					wr_cnt = 1'b1;
					wv = merge(s.cnt, s.wdata, s.wstrb) & CMASK;
				end
				OFF_STAT: ;
				OFF_CLR:  clr = s.wstrb[0] ? s.wdata[ST_W-1:0] : '0;
				OFF_IE: begin
					wv = merge({25'h0, s.ie}, s.wdata, s.wstrb);
					next_s.ie = wv[ST_W-1:0];
				end
				OFF_DMAE: begin
					wv = merge({25'h0, s.dmae}, s.wdata, s.wstrb);
					next_s.dmae = wv[ST_W-1:0];
				end
				OFF_DT: begin
					wv = merge({24'h0, s.dt}, s.wdata, s.wstrb);
					next_s.dt = wv[7:0];
				end
				OFF_MODE: begin
					wv = merge({20'h0, s.mode}, s.wdata, s.wstrb);
					next_s.mode = wv[11:0];
				end
				default: begin
					hit = 1'b0;
					for (int i = 0; i < NUM_CH; i++) begin
						if (s.awaddr == OFF_CCR0 + 8'(4 * i)) begin
							hit = 1'b1;
							next_s.ccr[i] = merge(s.ccr[i], s.wdata, s.wstrb) & CMASK;
						end
					end
				end
			endcase
			next_s.rsp.bvalid = 1'b1;
			next_s.rsp.bresp  = hit ? RESP_OK : RESP_ERR;
		end

		////////////////////////////////////////////////////////////////////////
		// bus read path
		if (s.rsp.rvalid && axi_req.rready) begin
			next_s.rsp.rvalid = 1'b0;
		end
		if (axi_req.arvalid && s.rsp.arready) begin
			next_s.rsp.rvalid = 1'b1;
			next_s.rsp.rresp  = RESP_OK;
			case (axi_req.araddr)
				OFF_CTRL: next_s.rsp.rdata = {24'h0, s.ctrl};
				OFF_PSC:  next_s.rsp.rdata = {16'h0, s.psc};
				OFF_ARR:  next_s.rsp.rdata = s.arr;
				OFF_CNT:  next_s.rsp.rdata = s.cnt;
				OFF_STAT: next_s.rsp.rdata = {25'h0, s.status};
				OFF_CLR:  next_s.rsp.rdata = 32'h0;
				OFF_IE:   next_s.rsp.rdata = {25'h0, s.ie};
				OFF_DMAE: next_s.rsp.rdata = {25'h0, s.dmae};
				OFF_DT:   next_s.rsp.rdata = {24'h0, s.dt};
				OFF_MODE: next_s.rsp.rdata = {20'h0, s.mode};
				default: begin
					next_s.rsp.rdata = 32'h0;
					next_s.rsp.rresp = RESP_ERR;
					for (int i = 0; i < NUM_CH; i++) begin
						if (axi_req.araddr == OFF_CCR0 + 8'(4 * i)) begin
							next_s.rsp.rdata = s.ccr[i];
							next_s.rsp.rresp = RESP_OK;
						end
					end
				end
			endcase
		end

		////////////////////////////////////////////////////////////////////////
		// prescaler and counter
		if (run) begin
			if (s.pcnt >= s.psc) begin
				next_s.pcnt = 16'h0;
				tick = 1'b1;
			end else begin
				next_s.pcnt = s.pcnt + 16'h1;
			end
		end
		if (wr_cnt) begin
			next_s.cnt = wv;
		end else if (run && sms == SM_ENC) begin
			// x4 quadrature: a edge up when a differs from b, b edge up when equal
			if (ch_in[0] != s.in_q[0]) begin
				st = step(s.cnt, s.arr, ch_in[0] == ch_in[1]);
			end else if (ch_in[1] != s.in_q[1]) begin
				st = step(s.cnt, s.arr, ch_in[0] != ch_in[1]);
			end else begin
				st = {1'b0, s.cnt};
			end
			{upd, next_s.cnt} = st;
		end else if (tick) begin
			if (s.ctrl[CTRL_CENTER] && !UP_ONLY) begin
				if (s.arr == 32'h0) begin
					next_s.cnt = 32'h0;
				end else if (!s.cdown && s.cnt >= s.arr) begin
					next_s.cdown = 1'b1;
					next_s.cnt   = s.arr - 32'h1;
					upd = 1'b1;
				end else if (s.cdown && s.cnt == 32'h0) begin
					next_s.cdown = 1'b0;
					next_s.cnt   = 32'h1;
					upd = 1'b1;
				end else begin
					next_s.cnt = s.cdown ? s.cnt - 32'h1 : s.cnt + 32'h1;
				end
			end else begin
				st = step(s.cnt, s.arr, s.ctrl[CTRL_DOWN] && !UP_ONLY);
				{upd, next_s.cnt} = st;
			end
		end
		next_s.cnt = next_s.cnt & CMASK;

		// hall sensors: capture the interval and restart
		if (run && sms == SM_HALL && (^ch_in[2:0] != ^s.in_q[2:0])) begin
			set[ST_HALL]  = 1'b1;
			next_s.ccr[0] = s.cnt;
			next_s.cnt    = 32'h0;
		end
		// trigger start from another timer
		if (sms == SM_TRIG && trig_in && !s.trig_q) begin
			set[ST_TRG]          = 1'b1;
			next_s.ctrl[CTRL_EN] = 1'b1;
			next_s.cnt           = 32'h0;
			next_s.pcnt          = 16'h0;
		end
		set[ST_UPD] = upd;
		if (upd && s.ctrl[CTRL_OPM]) begin
			next_s.ctrl[CTRL_EN] = 1'b0;
		end

		////////////////////////////////////////////////////////////////////////
		// channels
		for (int i = 0; i < NUM_CH; i++) begin
			m = mpwt_cc_mode_t'(s.mode[3*i +: 3]);
			unique case (m)
				CC_OFF: ;
				CC_CAP_RISE: begin
					if (ch_in[i] && !s.in_q[i]) begin
						next_s.ccr[i] = s.cnt;
						set[ST_CC0 + i] = 1'b1;
					end
				end
				CC_CAP_FALL: begin
					if (!ch_in[i] && s.in_q[i]) begin
						next_s.ccr[i] = s.cnt;
						set[ST_CC0 + i] = 1'b1;
					end
				end
				CC_TOGGLE: begin
					if (tick && s.cnt == s.ccr[i]) begin
						next_s.ch_out[i] = !s.ch_out[i];
						set[ST_CC0 + i] = 1'b1;
					end
				end
				CC_PWM: begin
					// ccr 0 is always low, ccr above reload always high
					next_s.ch_out[i] = next_s.cnt < s.ccr[i];
					if (tick && s.cnt == s.ccr[i]) begin
						set[ST_CC0 + i] = 1'b1;
					end
				end
				default: ;
			endcase
			next_s.ch_oe[i] = s.ctrl[CTRL_OE] && (m == CC_TOGGLE || m == CC_PWM);
		end

		////////////////////////////////////////////////////////////////////////
		// events, interrupt, dma, trigger out
		next_s.status   = (s.status & ~clr) | set;
		next_s.irq      = |(next_s.status & next_s.ie);
		next_s.dma_req  = HAS_DMA ? (set & s.dmae) : '0;
		next_s.trig_out = upd;
		next_s.in_q     = ch_in;
		next_s.trig_q   = trig_in;
		next_s.rsp.awready = !next_s.aw_held && !next_s.rsp.bvalid;
		next_s.rsp.wready  = !next_s.w_held && !next_s.rsp.bvalid;
		next_s.rsp.arready = !next_s.rsp.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s     <= '0;
			s.arr <= ARR_RST & CMASK;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs and complementary pairs
	assign axi_rsp  = s.rsp;
	assign trig_out = s.trig_out;
	assign irq      = s.irq;
	assign dma_req  = s.dma_req;
	assign ch_oe    = s.ch_oe;

	for (genvar i = 0; i < 4; i++) begin : g_ch
		if (i < NUM_COMPL) begin : g_pair
			mpwt_deadtime u_dt (
				.aclk    (aclk),
				.aresetn (aresetn),
				.ref_lvl (s.ch_out[i]),
				.en      (s.ctrl[CTRL_OE]),
				.dt      (s.dt),
				.out_p   (ch_out[i]),
				.out_n   (ch_out_n[i])
			);
		end else begin : g_single
			assign ch_out[i] = s.ch_out[i];
			if (i < 3) begin : g_nn
				assign ch_out_n[i] = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	a_freeze_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		dbg_halt && s.ctrl[CTRL_FRZ] && sms == SM_FREE && !wr_cnt |=> s.cnt == $past(s.cnt))
		else $error("counter moved while frozen");

	a_presc_step: assert property (@(posedge aclk) disable iff (!aresetn)
		run && sms == SM_FREE && s.pcnt < s.psc |=> s.pcnt == $past(s.pcnt) + 16'h1 && !trig_out)
		else $error("prescaler did not advance");

	a_up_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && sms == SM_FREE && !s.ctrl[CTRL_CENTER] && (!s.ctrl[CTRL_DOWN] || UP_ONLY)
		&& s.cnt >= s.arr && !wr_cnt |=> s.cnt == 32'h0 && s.status[ST_UPD] && trig_out)
		else $error("up wrap missed update");

	a_down_reload: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && sms == SM_FREE && !s.ctrl[CTRL_CENTER] && s.ctrl[CTRL_DOWN] && !UP_ONLY
		&& s.cnt == 32'h0 && !wr_cnt |=> s.cnt == ($past(s.arr) & CMASK))
		else $error("down count did not reload");

	a_opm_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		upd && s.ctrl[CTRL_OPM] |=> !s.ctrl[CTRL_EN])
		else $error("one-pulse did not stop");

	a_pwm_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		s.mode[2:0] == 3'(CC_PWM) && s.ccr[0] == 32'h0 |=> !s.ch_out[0])
		else $error("zero duty not inactive");

	a_dma_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		upd && s.dmae[ST_UPD] |=> dma_req[ST_UPD] == HAS_DMA ##1 (!dma_req[ST_UPD] || $past(upd)))
		else $error("dma request wrong");

	a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		s.status[ST_UPD] && !(wr_fire && s.awaddr == OFF_CLR) |=> s.status[ST_UPD])
		else $error("status flag lost");

	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		irq == |(s.status & s.ie))
		else $error("interrupt does not follow enabled status");

endmodule

/* File: dv/mpwt_pins_model.sv */
// model of the far side: encoder, hall sensors and one power stage pair
// assumes: timer pins synchronous to aclk; an undriven pin reads low
`timescale 1ns/1ps
module mpwt_pins_model (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// timer pins
	input  wire logic [3:0] ch_out,
	input  wire logic [3:0] ch_oe,
	input  wire logic [2:0] ch_out_n,
	output logic [3:0]      ch_in,
	// observations
	output logic [7:0]      gap,
	output logic            overlap
);
	logic [1:0] ph = 2'h0;
	logic       hl = 1'b0;
	logic [7:0] lowc;
	logic       hi_p;

	////////////////////////////////////////////////////////////////
	// quadrature on lines 0 and 1, third sensor on line 2
	assign ch_in = {1'b0, hl, ph[1], ph[1] ^ ph[0]};
	assign hi_p  = ch_out[0] & ch_oe[0];

	task automatic enc(input logic fwd);
		@(posedge aclk);
		ph <= fwd ? ph + 2'h1 : ph - 2'h1;
		repeat (2) @(posedge aclk);
	endtask

	task automatic hall;
		@(posedge aclk);
		hl <= ~hl;
		repeat (2) @(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////
	// power stage: flag shoot-through, keep length of last dead gap
	always @(posedge aclk) begin
		if (!aresetn) begin
			lowc    <= 8'h0;
			gap     <= 8'h0;
			overlap <= 1'b0;
		end else begin
			if (hi_p && ch_out_n[0]) begin
				overlap <= 1'b1;
			end
			if (!hi_p && !ch_out_n[0]) begin
				lowc <= lowc + 8'h1;
			end else begin
				if (lowc != 8'h0) begin
					gap <= lowc;
				end
				lowc <= 8'h0;
			end
		end
	end
endmodule

/* File: dv/multichannel_pwm_timer_bench.sv */
// self-checking bench: axi4-lite register tasks, pin model, pin checks
// assumes: default parameters, a 16-bit counter with four channels
`timescale 1ns/1ps
module multichannel_pwm_timer_bench;
	import mpwt_pkg::*;
	localparam int TBL [4][4] = '{'{0, 3, 1, 4}, '{2, 1, 1, 6}, '{0, 3, 3, 4}, '{0, 3, 5, 3}};
	logic            aclk     = 1'b0;
	logic            aresetn  = 1'b0;
	mpwt_axi_req_t   req      = '0;
	mpwt_axi_rsp_t   rsp;
	logic [3:0]      ch_in;
	logic [3:0]      ch_out;
	logic [3:0]      ch_oe;
	logic [2:0]      ch_out_n;
	logic            dbg_halt = 1'b0;
	logic            trig_in  = 1'b0;
	logic            trig_out;
	logic            irq;
	logic [ST_W-1:0] dma_req;
	logic [7:0]      gap;
	logic            overlap;
	int              fails       = 0;
	int              check_count = 0;

	always #2.5 aclk = ~aclk;

	mpwt_timer dut_u (.aclk, .aresetn, .axi_req(req), .axi_rsp(rsp), .ch_in, .ch_out, .ch_oe,
		.ch_out_n, .dbg_halt, .trig_in, .trig_out, .irq, .dma_req);
	mpwt_pins_model pins_u (.aclk, .aresetn, .ch_out, .ch_oe, .ch_out_n, .ch_in, .gap, .overlap);

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic hang;
		fails++;
		$display("MISMATCH %0t: wait ran out", $time);
		summarize();
	endtask

	// both tasks start and end just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK);
		mpwt_axi_req_t q;
		mpwt_axi_rsp_t r;
		bit            done;
		done = 1'b0;
		req.awaddr  <= a;
		req.awvalid <= 1'b1;
		req.wdata   <= d;
		req.wstrb   <= 4'hf;
		req.wvalid  <= 1'b1;
		req.bready  <= 1'b1;
		for (int i = 0; i < 64 && !done; i++) begin
			@(negedge aclk);
			q = req;
			r = rsp;
			@(posedge aclk);
			if (q.awvalid && r.awready) req.awvalid <= 1'b0;
			if (q.wvalid && r.wready) req.wvalid <= 1'b0;
			if (q.bready && r.bvalid) begin
				done = 1'b1;
				chk(r.bresp, er);
			end
		end
		if (!done) hang();
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OK);
		mpwt_axi_req_t q;
		mpwt_axi_rsp_t r;
		bit            done;
		done = 1'b0;
		d = 'x;
		req.araddr  <= a;
		req.arvalid <= 1'b1;
		req.rready  <= 1'b1;
		for (int i = 0; i < 64 && !done; i++) begin
			@(negedge aclk);
			q = req;
			r = rsp;
			@(posedge aclk);
			if (q.arvalid && r.arready) req.arvalid <= 1'b0;
			if (q.rready && r.rvalid) begin
				done = 1'b1;
				d = r.rdata;
				chk(r.rresp, er);
			end
		end
		if (!done) hang();
	endtask

	// cycles between two trigger pulses; dma bit seen with the second
	task automatic per(output int n, output logic dq);
		int k;
		k = 0;
		n = 0;
		do begin @(negedge aclk); k++; end while (trig_out !== 1'b1 && k < 999);
		do begin @(negedge aclk); n++; end while (trig_out !== 1'b1 && n < 999);
		dq = dma_req[ST_UPD];
		if (n >= 999) hang();
		@(posedge aclk);
	endtask

	task automatic ones(input int cyc, output int n);
		n = 0;
		// let the dead-time pair settle before counting
		repeat (2) @(posedge aclk);
		repeat (cyc) begin
			@(negedge aclk);
			n += int'(ch_out[0] === 1'b1);
		end
		@(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		logic [31:0] e;
		int          n;
		logic        dq;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OFF_ARR, d);
		chk(d, 32'h0000_ffff);
		rd(OFF_CNT, d);
		chk(d, 32'h0);
		rd(8'h2c, d, RESP_ERR);
		chk(d, 32'h0);
		// pwm on channel 0 with update interrupt and dma
		wr(OFF_ARR, 32'h3);
		wr(OFF_CCR0, 32'h2);
		wr(OFF_MODE, 32'h4);
		wr(OFF_IE, 32'h1);
		wr(OFF_DMAE, 32'h1);
		wr(OFF_CTRL, 32'h81);
		ones(8, n);
		// dt 0 still eats one of the two high cycles per period
		chk(n, 2);
		per(n, dq);
		chk(n, 4);
		chk(dq, 1'b1);
		@(negedge aclk);
		chk(irq, 1'b1);
		chk(ch_oe, 32'h1);
		@(posedge aclk);
		wr(OFF_IE, 32'h0);
		@(negedge aclk);
		chk(irq, 1'b0);
		@(posedge aclk);
		wr(OFF_CTRL, 32'h80);
		wr(OFF_CLR, 32'h7f);
		rd(OFF_STAT, d);
		chk(d[ST_UPD], 1'b0);
		// duty extremes
		wr(OFF_CCR0, 32'h0);
		wr(OFF_CTRL, 32'h81);
		ones(8, n);
		chk(n, 0);
		wr(OFF_CCR0, 32'h4);
		ones(8, n);
		chk(n, 8);
		// prescaler and counting directions
		for (int i = 0; i < 4; i++) begin
			wr(OFF_CTRL, 32'h0);
			wr(OFF_CNT, 32'h0);
			wr(OFF_PSC, TBL[i][0]);
			wr(OFF_ARR, TBL[i][1]);
			wr(OFF_CTRL, TBL[i][2]);
			per(n, dq);
			per(n, dq);
			chk(n, TBL[i][3]);
		end
		// one-pulse: stops itself at the first wrap
		wr(OFF_CTRL, 32'h9);
		repeat (12) @(posedge aclk);
		rd(OFF_CTRL, d);
		chk(d[CTRL_EN], 1'b0);
		rd(OFF_CNT, d);
		chk(d, 32'h0);
		// debug freeze
		wr(OFF_ARR, 32'hffff);
		wr(OFF_CTRL, 32'h11);
		dbg_halt <= 1'b1;
		rd(OFF_CNT, d);
		rd(OFF_CNT, e);
		chk(e, d);
		dbg_halt <= 1'b0;
		@(posedge aclk);
		rd(OFF_CNT, e);
		chk(e, d + 32'h1);
		// start by trigger from another timer
		wr(OFF_CTRL, 32'h40);
		trig_in <= 1'b1;
		@(posedge aclk);
		trig_in <= 1'b0;
		rd(OFF_CTRL, d);
		chk(d[CTRL_EN], 1'b1);
		// quadrature encoder
		wr(OFF_CTRL, 32'h21);
		wr(OFF_CNT, 32'h0);
		repeat (5) pins_u.enc(1'b1);
		repeat (2) pins_u.enc(1'b0);
		rd(OFF_CNT, d);
		chk(d, 32'h3);
		// hall sensor change
		wr(OFF_CTRL, 32'h61);
		wr(OFF_CLR, 32'h7f);
		pins_u.hall();
		rd(OFF_STAT, d);
		chk(d[ST_HALL], 1'b1);
		// complementary pair with dead time
		wr(OFF_CTRL, 32'h0);
		wr(OFF_CNT, 32'h0);
		wr(OFF_ARR, 32'hf);
		wr(OFF_CCR0, 32'h8);
		wr(OFF_DT, 32'h2);
		wr(OFF_CTRL, 32'h81);
		repeat (60) @(posedge aclk);
		chk(gap, 8'h3);
		chk(overlap, 1'b0);
		summarize();
	end
endmodule
